/* File: rtl/csi2_framer_pkg.sv */
// constants, carriers and helpers of the csi-2 packet framer
// assumes one 50 MHz clock and a plain byte-wide register port
// Behaviour
// - per-port frame and line polarity invert
// - first line valid only after minimum setup from frame valid
// - short setup drops first line, or forwards
// - no timing check at frame end
// - sync packets are 32-bit short packets
// - long packet: header, byte payload, footer
// - word count equals payload byte count
// - header ecc corrects one, detects two
// - footer holds crc over payload
// - identifier: channel high 2, type low 6
// - csi input passes data type through
// - raw input uses raw identifier register
// - up to four channels interleaved out
// - per-port remap of every input channel
// - two-bit field selects lane rate
// - 800M and 1.6G derive timing automatically
// - payload carried raw, byte words
// - frame and line start and end packets
package csi2_framer_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_RATE    = 8'h1f;
	localparam logic [7:0] ADDR_RAW10   = 8'h70;
	localparam logic [7:0] ADDR_RAW12   = 8'h71;
	localparam logic [7:0] ADDR_POL     = 8'h7c;
	localparam logic [7:0] ADDR_MINSET  = 8'hbc;
	localparam logic [7:0] ADDR_REMAP0  = 8'h80;
	localparam logic [7:0] ADDR_MODE    = 8'h84;
	localparam logic [7:0] ADDR_FWD     = 8'h85;
	localparam logic [7:0] ADDR_TIMING  = 8'h86;
	localparam logic [7:0] ADDR_STATUS  = 8'h87;

	localparam logic [7:0] RST_RATE     = 8'h00;
	localparam logic [7:0] RST_RAW10    = 8'h2b;
	localparam logic [7:0] RST_RAW12    = 8'h2c;
	localparam logic [7:0] RST_POL      = 8'h00;
	localparam logic [7:0] RST_MINSET   = 8'h80;
	localparam logic [7:0] RST_REMAP    = 8'he4;
	localparam logic [7:0] RST_ZERO     = 8'h00;

	// field positions
	localparam int TIMING_OVR_BIT = 7;
	localparam int LINE_POL_LSB   = 4;
	localparam int RAW12_SEL_LSB  = 4;
	localparam int OVF_LSB        = 4;

	// ---------------------------------------------------------------
	// packet constants
	// ---------------------------------------------------------------
	localparam logic [5:0]  DT_FS        = 6'h00;
	localparam logic [5:0]  DT_FE        = 6'h01;
	localparam logic [5:0]  DT_LS        = 6'h02;
	localparam logic [5:0]  DT_LE        = 6'h03;
	localparam logic [1:0]  HDR_LAST     = 2'h3;
	localparam logic [15:0] CRC_INIT     = 16'hffff;
	localparam logic [15:0] CRC_POLY     = 16'h8408;
	localparam logic [1:0]  RATE_1600    = 2'b00;
	localparam logic [1:0]  RATE_800     = 2'b10;
	localparam logic [1:0]  RATE_400     = 2'b11;
	localparam logic [23:0] ECC_MASK [6] = '{24'hf12cb7, 24'hf2555b,
		24'h749a6d, 24'hb8e38e, 24'hdf03f0, 24'heffc00};

	// ---------------------------------------------------------------
	// carriers and states
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       link_clk;
		logic       frame;
		logic       line;
		logic [7:0] data;
		logic [1:0] vc;
		logic [5:0] dt;
	} port_in_t;

	typedef struct packed {
		logic [7:0] data;
		logic       first;
		logic       last;
	} hs_beat_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_HDR  = 2'b01,
		S_PAY  = 2'b11,
		S_CRC  = 2'b10
	} tx_state_t;

	typedef enum logic [2:0] {
		K_FS, K_LS, K_LONG, K_LE, K_FE
	} pkt_kind_t;

	function automatic logic [7:0] ecc_calc(input logic [23:0] d);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 6; i++)
		begin
			e[i] = ^(d & ECC_MASK[i]);
		end
		return e;
	endfunction : ecc_calc

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

endpackage : csi2_framer_pkg

/* File: rtl/csi2_tx_packet_framer.sv */
// csi-2 packet framer: per-port raw framing in, packet bytes out
// assumes port inputs are asynchronous and the sink may stall
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module csi2_tx_packet_framer #(
	parameter int          NPORTS      = 4,
	parameter int          DEPTH       = 64,
	parameter logic [7:0]  TIMING_1600 = 8'h10,
	parameter logic [7:0]  TIMING_800  = 8'h08
) (
	input  wire logic                                  clock,
	input  wire logic                                  nrst,
	input  wire logic [7:0]                            reg_addr,
	input  wire logic [7:0]                            reg_wdata,
	input  wire logic                                  reg_write,
	input  wire logic                                  reg_read,
	output logic      [7:0]                            reg_rdata,
	input  wire csi2_framer_pkg::port_in_t [NPORTS-1:0] port_in,
	output csi2_framer_pkg::hs_beat_t                  hs_beat,
	output logic                                       hs_valid,
	input  wire logic                                  hs_ready,
	output logic      [1:0]                            lane_rate,
	output logic      [7:0]                            lane_timing,
	output logic                                       lane_timing_missing
);
	import csi2_framer_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int LW = PW + 1;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] rate_reg, raw10_reg, raw12_reg, pol_reg, minset_reg;
	logic [7:0] mode_reg, fwd_reg, timing_reg, status_reg;
	logic [7:0] status_next;
	logic [7:0] remap_reg [NPORTS];
	logic [7:0] rdata_reg;
	logic [7:0] rd_mux;
	logic [NPORTS-1:0] err_set, ovf_set;

	wire wr_rate   = reg_write && reg_addr == ADDR_RATE;
	wire wr_raw10  = reg_write && reg_addr == ADDR_RAW10;
	wire wr_raw12  = reg_write && reg_addr == ADDR_RAW12;
	wire wr_pol    = reg_write && reg_addr == ADDR_POL;
	wire wr_minset = reg_write && reg_addr == ADDR_MINSET;
	wire wr_mode   = reg_write && reg_addr == ADDR_MODE;
	wire wr_fwd    = reg_write && reg_addr == ADDR_FWD;
	wire wr_timing = reg_write && reg_addr == ADDR_TIMING;
	wire wr_status = reg_write && reg_addr == ADDR_STATUS;
	wire [7:0] remap_off = reg_addr - ADDR_REMAP0;
	wire remap_hit = reg_addr >= ADDR_REMAP0 &&
		{24'h0, remap_off} < NPORTS;
	wire [1:0] remap_idx = remap_off[1:0];

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			rate_reg   <= RST_RATE;
			raw10_reg  <= RST_RAW10;
			raw12_reg  <= RST_RAW12;
			pol_reg    <= RST_POL;
			minset_reg <= RST_MINSET;
			mode_reg   <= RST_ZERO;
			fwd_reg    <= RST_ZERO;
			timing_reg <= RST_ZERO;
		end
		else
		begin
			if (wr_rate)   rate_reg   <= reg_wdata;
			if (wr_raw10)  raw10_reg  <= reg_wdata;
			if (wr_raw12)  raw12_reg  <= reg_wdata;
			if (wr_pol)    pol_reg    <= reg_wdata;
			if (wr_minset) minset_reg <= reg_wdata;
			if (wr_mode)   mode_reg   <= reg_wdata;
			if (wr_fwd)    fwd_reg    <= reg_wdata;
			if (wr_timing) timing_reg <= reg_wdata;
		end
	end

	// remap per port: two bits per incoming channel
	for (genvar g = 0; g < NPORTS; g++)
	begin : g_remap
		always_ff @(posedge clock)
		begin
			if (!nrst)
				remap_reg[g] <= RST_REMAP;
			else if (remap_hit && remap_off == 8'(g) && reg_write)
				remap_reg[g] <= reg_wdata;
		end
	end

	// sticky errors, write one to clear, a new event wins
	assign status_next = ({{(8-NPORTS){1'b0}}, ovf_set} << OVF_LSB) |
		{{(8-NPORTS){1'b0}}, err_set} |
		(status_reg & ~(wr_status ? reg_wdata : 8'h00));

	always_ff @(posedge clock)
	begin
		if (!nrst)
			status_reg <= RST_ZERO;
		else
			status_reg <= status_next;
	end

	assign rd_mux =
		reg_addr == ADDR_RATE   ? rate_reg   :
		reg_addr == ADDR_RAW10  ? raw10_reg  :
		reg_addr == ADDR_RAW12  ? raw12_reg  :
		reg_addr == ADDR_POL    ? pol_reg    :
		reg_addr == ADDR_MINSET ? minset_reg :
		reg_addr == ADDR_MODE   ? mode_reg   :
		reg_addr == ADDR_FWD    ? fwd_reg    :
		reg_addr == ADDR_TIMING ? timing_reg :
		reg_addr == ADDR_STATUS ? status_reg :
		remap_hit ? remap_reg[remap_idx] : 8'h00;

	always_ff @(posedge clock)
	begin
		if (!nrst)
			rdata_reg <= 8'h00;
		else if (reg_read)
			rdata_reg <= rd_mux;
	end
	assign reg_rdata = rdata_reg;

	// ---------------------------------------------------------------
	// lane rate and timing
	// ---------------------------------------------------------------
	wire [1:0] rate_sel = rate_reg[1:0];
	wire       ovr      = timing_reg[TIMING_OVR_BIT];
	assign lane_rate   = rate_sel;
	assign lane_timing =
		rate_sel == RATE_1600 ? TIMING_1600 :
		rate_sel == RATE_800  ? TIMING_800  :
		{1'b0, timing_reg[6:0]};
	// 400M relies on host-set override
	assign lane_timing_missing = rate_sel == RATE_400 && !ovr;

	// ---------------------------------------------------------------
	// per-port capture
	// ---------------------------------------------------------------
	logic [NPORTS-1:0] fs_pend, fe_pend, line_rdy;
	logic [NPORTS-1:0] fs_clr, fe_clr, line_clr;
	logic [7:0]        rd_byte [NPORTS];
	logic [LW-1:0]     line_len [NPORTS];
	logic [1:0]        in_vc [NPORTS];
	logic [5:0]        in_dt [NPORTS];
	logic [PW-1:0]     rd_ptr;

	for (genvar p = 0; p < NPORTS; p++)
	begin : g_port
		port_in_t      s1_reg, s2_reg;
		logic          lclk_d_reg, fq_d_reg, lq_d_reg;
		logic          seen_reg, cap_reg;
		logic [8:0]    cnt_reg;
		logic [LW-1:0] wptr_reg;
		logic [7:0]    mem [DEPTH];
		wire edge_w = s2_reg.link_clk && !lclk_d_reg;
		wire fq = s2_reg.frame ^ pol_reg[p];
		wire lq = s2_reg.line ^ pol_reg[LINE_POL_LSB + p];
		wire fq_rise = edge_w && fq && !fq_d_reg;
		wire fq_fall = edge_w && !fq && fq_d_reg;
		wire lq_rise = edge_w && fq && lq && !lq_d_reg;
		wire lq_fall = edge_w && !lq && lq_d_reg && cap_reg;
		wire short_w = lq_rise && !seen_reg &&
			cnt_reg < {1'b0, minset_reg};
		wire drop_w = short_w && !fwd_reg[p];
		wire busy_w = lq_rise && line_rdy[p];
		wire start_w = lq_rise && !drop_w && !busy_w;
		wire wr_w = edge_w && lq &&
			(start_w || (cap_reg && wptr_reg < LW'(DEPTH)));

		assign err_set[p] = short_w;
		assign ovf_set[p] = busy_w;
		assign rd_byte[p] = mem[rd_ptr];
		assign line_len[p] = wptr_reg;
		assign in_vc[p] = s2_reg.vc;
		assign in_dt[p] = s2_reg.dt;

		always_ff @(posedge clock)
		begin
			if (!nrst)
			begin
				s1_reg     <= '0;
				s2_reg     <= '0;
				lclk_d_reg <= 1'b0;
			end
			else
			begin
				s1_reg     <= port_in[p];
				s2_reg     <= s1_reg;
				lclk_d_reg <= s2_reg.link_clk;
			end
		end

		always_ff @(posedge clock)
		begin
			if (wr_w)
				mem[start_w ? '0 : wptr_reg[PW-1:0]] <= s2_reg.data;
		end

		always_ff @(posedge clock)
		begin
			if (!nrst)
			begin
				fq_d_reg <= 1'b0;
				lq_d_reg <= 1'b0;
				seen_reg <= 1'b0;
				cap_reg  <= 1'b0;
				cnt_reg  <= 9'h000;
				wptr_reg <= '0;
			end
			else if (edge_w)
			begin
				fq_d_reg <= fq;
				lq_d_reg <= lq;
				// setup counted in link clocks before first line
				if (fq_rise)
					cnt_reg <= 9'h000;
				else if (fq && !seen_reg && !lq && cnt_reg != 9'h1ff)
					cnt_reg <= cnt_reg + 9'h001;
				if (fq_rise)
					seen_reg <= 1'b0;
				else if (lq_rise)
					seen_reg <= 1'b1;
				if (start_w)
					cap_reg <= 1'b1;
				else if (!lq || !fq)
					cap_reg <= 1'b0;
				if (start_w)
					wptr_reg <= LW'(1);
				else if (wr_w)
					wptr_reg <= wptr_reg + LW'(1);
			end
		end

		// event flags: the hardware set wins over the clear
		always_ff @(posedge clock)
		begin
			if (!nrst)
			begin
				fs_pend[p]  <= 1'b0;
				fe_pend[p]  <= 1'b0;
				line_rdy[p] <= 1'b0;
			end
			else
			begin
				fs_pend[p]  <= fq_rise || (fs_pend[p] && !fs_clr[p]);
				fe_pend[p]  <= fq_fall || (fe_pend[p] && !fe_clr[p]);
				line_rdy[p] <= lq_fall ||
					(line_rdy[p] && !line_clr[p]);
			end
		end
	end

	// ---------------------------------------------------------------
	// packet transmitter
	// ---------------------------------------------------------------
	tx_state_t         state_reg;
	pkt_kind_t         kind_reg;
	logic [1:0]        port_reg, rr_reg;
	logic [NPORTS-1:0] infr_reg;
	logic [1:0]        idx_reg;
	logic [LW-1:0]     pcnt_reg;
	logic [15:0]       wc_reg, crc_reg;
	logic [7:0]        di_reg;
	hs_beat_t          beat_reg;
	logic              valid_reg;

	// choose next port with work, round robin
	logic       pick_ok;
	logic [1:0] pick;
	pkt_kind_t  pick_kind;
	always_comb
	begin
		logic [1:0] c;
		pick_ok   = 1'b0;
		pick      = rr_reg;
		pick_kind = K_FS;
		c         = 2'b00;
		for (int i = NPORTS - 1; i >= 0; i--)
		begin
			c = 2'(int'(rr_reg) + i);
			if (fs_pend[c] && !infr_reg[c])
			begin
				pick_ok = 1'b1; pick = c; pick_kind = K_FS;
			end
			else if (line_rdy[c] && infr_reg[c])
			begin
				pick_ok = 1'b1; pick = c; pick_kind = K_LS;
			end
			else if (fe_pend[c] && infr_reg[c])
			begin
				pick_ok = 1'b1; pick = c; pick_kind = K_FE;
			end
		end
	end

	// identifier: raw register or passed type, remapped channel
	// long packet keeps the port of its line start
	wire [1:0] src     = kind_reg == K_LONG ? port_reg : pick;
	wire       raw12_w = mode_reg[RAW12_SEL_LSB + src];
	wire [7:0] raw_id  = raw12_w ? raw12_reg : raw10_reg;
	wire       csi_w   = mode_reg[src];
	wire [1:0] vc_src  = csi_w ? in_vc[src] : raw_id[7:6];
	wire [5:0] dt_src  = csi_w ? in_dt[src] : raw_id[5:0];
	wire [1:0] vc_out  = remap_reg[src][2*vc_src +: 2];
	wire [5:0] dt_sel  =
		pick_kind == K_FS ? DT_FS : pick_kind == K_FE ? DT_FE : DT_LS;
	// short packets use reserved types 0x00-0x0f
	wire [7:0] di_short = {vc_out, dt_sel};
	wire [7:0] di_long  = {vc_out, dt_src};

	wire go      = state_reg != S_IDLE && (!valid_reg || hs_ready);
	wire is_long = kind_reg == K_LONG;
	wire [7:0] hdr_byte =
		idx_reg == 2'd0 ? di_reg :
		idx_reg == 2'd1 ? wc_reg[7:0] :
		idx_reg == 2'd2 ? wc_reg[15:8] :
		ecc_calc({wc_reg, di_reg});
	assign rd_ptr = pcnt_reg[PW-1:0];
	wire [7:0] pay_byte = rd_byte[port_reg];
	wire [7:0] tx_byte =
		state_reg == S_HDR ? hdr_byte :
		state_reg == S_PAY ? pay_byte :
		idx_reg == 2'd0 ? crc_reg[7:0] : crc_reg[15:8];
	wire hdr_end = state_reg == S_HDR && idx_reg == HDR_LAST;
	wire pay_end = state_reg == S_PAY && pcnt_reg + LW'(1) == wc_reg[LW-1:0];
	wire crc_end = state_reg == S_CRC && idx_reg == 2'd1;
	wire pkt_end = go && ((hdr_end && !is_long) || crc_end);
	wire empty_w = line_len[port_reg] == '0;

	always_comb
	begin
		fs_clr   = '0;
		fe_clr   = '0;
		line_clr = '0;
		if (pkt_end && kind_reg == K_FS)
			fs_clr[port_reg] = 1'b1;
		if (pkt_end && kind_reg == K_FE)
			fe_clr[port_reg] = 1'b1;
		if (pkt_end && kind_reg == K_LE)
			line_clr[port_reg] = 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state_reg <= S_IDLE;
			kind_reg  <= K_FS;
			port_reg  <= 2'b00;
			rr_reg    <= 2'b00;
			infr_reg  <= '0;
			idx_reg   <= 2'b00;
			pcnt_reg  <= '0;
			wc_reg    <= 16'h0000;
			di_reg    <= 8'h00;
			crc_reg   <= CRC_INIT;
		end
		else
		begin
			case (state_reg)
			S_IDLE:
				if (kind_reg == K_LONG || kind_reg == K_LE)
				begin
					// line sequence: long packet, then line end
					state_reg <= S_HDR;
					idx_reg   <= 2'b00;
					di_reg    <= kind_reg == K_LONG ?
						{di_reg[7:6], dt_src} : {di_reg[7:6], DT_LE};
					wc_reg    <= kind_reg == K_LONG ?
						16'(line_len[port_reg]) : 16'h0000;
				end
				else if (pick_ok)
				begin
					state_reg <= S_HDR;
					kind_reg  <= pick_kind;
					port_reg  <= pick;
					rr_reg    <= pick + 2'b01;
					idx_reg   <= 2'b00;
					di_reg    <= di_short;
					wc_reg    <= 16'h0000;
					if (pick_kind == K_FS)
						infr_reg[pick] <= 1'b1;
					if (pick_kind == K_FE)
						infr_reg[pick] <= 1'b0;
				end
			S_HDR:
				if (go)
				begin
					idx_reg  <= idx_reg + 2'b01;
					pcnt_reg <= '0;
					crc_reg  <= CRC_INIT;
					if (hdr_end && is_long)
					begin
						idx_reg   <= 2'b00;
						state_reg <= empty_w ? S_CRC : S_PAY;
					end
				end
			S_PAY:
				if (go)
				begin
					crc_reg  <= crc_step(crc_reg, pay_byte);
					pcnt_reg <= pcnt_reg + LW'(1);
					if (pay_end)
						state_reg <= S_CRC;
				end
			S_CRC:
				if (go)
					idx_reg <= idx_reg + 2'b01;
			default:
				state_reg <= S_IDLE;
			endcase
			if (pkt_end)
			begin
				state_reg <= S_IDLE;
				kind_reg  <= kind_reg == K_LS ? K_LONG :
					kind_reg == K_LONG ? K_LE : K_FS;
			end
		end
	end

	// long identifier keeps the channel from the pick, the data type is taken when it starts
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			beat_reg  <= '0;
			valid_reg <= 1'b0;
		end
		else if (go)
		begin
			beat_reg.data  <= tx_byte;
			beat_reg.first <= state_reg == S_HDR && idx_reg == 2'd0;
			beat_reg.last  <= (hdr_end && !is_long) || crc_end;
			valid_reg      <= 1'b1;
		end
		else if (hs_ready)
			valid_reg <= 1'b0;
	end

	assign hs_beat  = beat_reg;
	assign hs_valid = valid_reg;

endmodule : csi2_tx_packet_framer
`default_nettype wire

/* File: testbench/framer_checker.sv */
// assertions on the framer ports: stream framing, header and rate
// assumes one clock domain and binding to every framer instance
`timescale 1ns/100ps
`default_nettype none
module framer_checker #(
	parameter logic [7:0] TIMING_1600 = 8'h10,
	parameter logic [7:0] TIMING_800  = 8'h08
) (
	input wire logic                      clock,
	input wire logic                      nrst,
	input wire logic [7:0]                reg_addr,
	input wire logic [7:0]                reg_wdata,
	input wire logic                      reg_write,
	input wire csi2_framer_pkg::hs_beat_t hs_beat,
	input wire logic                      hs_valid,
	input wire logic                      hs_ready,
	input wire logic [1:0]                lane_rate,
	input wire logic [7:0]                lane_timing,
	input wire logic                      lane_timing_missing
);
	import csi2_framer_pkg::*;
	// ---------------------------------------------------------------
	// beat tracking
	// ---------------------------------------------------------------
	logic [15:0] idx_reg;
	logic [15:0] wc_reg;
	logic [7:0]  di_reg;
	logic        open_reg;
	wire         acc = hs_valid && hs_ready;
	wire [15:0]  cur_idx = hs_beat.first ? 16'h0000 : idx_reg;
	wire [7:0]   cur_di = hs_beat.first ? hs_beat.data : di_reg;
	wire         is_short = cur_di[5:0] <= 6'h0f;
	function automatic logic [7:0] hdr_par(input logic [23:0] d);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 6; i++)
			e[i] = ^(d & ECC_MASK[i]);
		return e;
	endfunction : hdr_par
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			idx_reg  <= 16'h0000;
			wc_reg   <= 16'h0000;
			di_reg   <= 8'h00;
			open_reg <= 1'b0;
		end
		else if (acc)
		begin
			idx_reg  <= cur_idx + 16'h0001;
			di_reg   <= cur_di;
			open_reg <= !hs_beat.last;
			if (cur_idx == 16'h0001)
				wc_reg[7:0] <= hs_beat.data;
			if (cur_idx == 16'h0002)
				wc_reg[15:8] <= hs_beat.data;
		end
	end
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_stalled;
		hs_valid && !hs_ready;
	endsequence
	sequence s_hdr_end;
		acc && cur_idx == 16'h0003;
	endsequence
	sequence s_rate_wr;
		reg_write && reg_addr == ADDR_RATE;
	endsequence
	property p_rate_taken;
		s_rate_wr |=> {6'h00, lane_rate} == ($past(reg_wdata) & 8'h03);
	endproperty
	a_beat_held: assert property (s_stalled |=> hs_valid && $stable(hs_beat)) else $error("beat changed while stalled");
	a_first_opens: assert property (hs_valid && !open_reg |-> hs_beat.first) else $error("packet without first beat");
	a_short_len: assert property (acc && hs_beat.last && is_short |-> cur_idx == 16'h0003) else $error("short packet not four bytes");
	a_long_len: assert property (acc && hs_beat.last && !is_short |-> cur_idx == wc_reg + 16'h0005) else $error("long length off count");
	a_short_zero: assert property (acc && is_short && (cur_idx == 16'h0001 || cur_idx == 16'h0002) |-> hs_beat.data == 8'h00) else $error("short data field not zero");
	a_hdr_ecc: assert property (s_hdr_end |-> hs_beat.data == hdr_par({wc_reg, di_reg})) else $error("header ecc wrong");
	a_rate_taken: assert property (p_rate_taken) else $error("rate field not applied");
	a_auto_timing: assert property ((lane_rate == RATE_1600 |-> lane_timing == TIMING_1600) and (lane_rate == RATE_800 |-> lane_timing == TIMING_800)) else $error("auto timing wrong");
	a_missing_cause: assert property (lane_timing_missing |-> lane_rate == RATE_400) else $error("timing flag without slow rate");
endmodule : framer_checker
bind csi2_tx_packet_framer framer_checker #(.TIMING_1600(TIMING_1600), .TIMING_800(TIMING_800)) chk (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .hs_beat(hs_beat), .hs_valid(hs_valid), .hs_ready(hs_ready), .lane_rate(lane_rate), .lane_timing(lane_timing), .lane_timing_missing(lane_timing_missing));
`default_nettype wire

/* File: testbench/csi2_sink_model.sv */
// downstream receiver model: takes beats, optionally stalls
// assumes the bench reads and clears the got queue
`timescale 1ns/100ps
`default_nettype none
module csi2_sink_model (
	input  wire logic                      clock,
	input  wire logic                      nrst,
	input  wire csi2_framer_pkg::hs_beat_t hs_beat,
	input  wire logic                      hs_valid,
	output logic                           hs_ready,
	input  wire logic                      slow
);
	import csi2_framer_pkg::*;
	logic [8:0] got [$];
	logic [2:0] ph_reg;
	// slow mode accepts one beat in eight
	assign hs_ready = nrst && (!slow || ph_reg == 3'h0);
	always @(posedge clock)
	begin
		ph_reg <= nrst ? ph_reg + 3'h1 : 3'h0;
		if (hs_valid && hs_ready)
			got.push_back({hs_beat.last, hs_beat.data});
	end
endmodule : csi2_sink_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench: register calls and raw frames on port 0
// assumes the sink model and the checker compile before it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import csi2_framer_pkg::*;
	localparam logic [7:0] T16 = 8'h10;
	localparam logic [7:0] T8  = 8'h08;
	localparam logic [7:0] AUTO_T [4] = '{T16, 8'h00, T8, 8'h00};
	logic           clock;
	logic           nrst;
	logic [7:0]     reg_addr;
	logic [7:0]     reg_wdata;
	logic           reg_write;
	logic           reg_read;
	logic [7:0]     reg_rdata;
	port_in_t [3:0] pin;
	hs_beat_t       hs_beat;
	logic           hs_valid;
	logic           hs_ready;
	logic [1:0]     lane_rate;
	logic [7:0]     lane_timing;
	logic           lane_timing_missing;
	logic           slow;
	logic           inv;
	logic [8:0]     exp_q [$];
	int             err_count;
	int             checks_done;
	csi2_tx_packet_framer #(.NPORTS(4), .DEPTH(8), .TIMING_1600(T16), .TIMING_800(T8)) DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_in(pin), .hs_beat(hs_beat), .hs_valid(hs_valid), .hs_ready(hs_ready), .lane_rate(lane_rate), .lane_timing(lane_timing), .lane_timing_missing(lane_timing_missing));
	csi2_sink_model sink (.clock(clock), .nrst(nrst), .hs_beat(hs_beat), .hs_valid(hs_valid), .hs_ready(hs_ready), .slow(slow));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("mismatches %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 check({1'b0, reg_rdata}, {1'b0, e});
	endtask : rd
	// one link clock of 160 ns; data inverts while line is low
	task automatic lk(input logic f, input logic l, input logic [7:0] d);
		pin[0].frame    <= f ^ inv;
		pin[0].line     <= l ^ inv;
		pin[0].data     <= l ? d : ~pin[0].data;
		pin[0].link_clk <= 1'b1;
		repeat (4) @(posedge clock);
		pin[0].link_clk <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : lk
	task automatic frame(input int setup, input int n);
		@(posedge clock);
		repeat (setup) lk(1'b1, 1'b0, 8'h00);
		for (int i = 0; i < n; i++)
			lk(1'b1, 1'b1, 8'h30 + 8'(i));
		lk(1'b1, 1'b0, 8'h00);
		lk(1'b0, 1'b0, 8'h00);
	endtask : frame
	function automatic logic [7:0] par(input logic [23:0] d);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 6; i++)
			e[i] = ^(d & ECC_MASK[i]);
		return e;
	endfunction : par
	task automatic push_short(input logic [7:0] di);
		exp_q.push_back({1'b0, di});
		exp_q.push_back(9'h000);
		exp_q.push_back(9'h000);
		exp_q.push_back({1'b1, par({16'h0000, di})});
	endtask : push_short
	task automatic push_line(input logic [1:0] vc, input logic [5:0] dt, input int n);
		logic [15:0] c;
		logic [7:0]  x;
		c = CRC_INIT;
		push_short({vc, DT_LS});
		exp_q.push_back({1'b0, vc, dt});
		exp_q.push_back({1'b0, 8'(n)});
		exp_q.push_back(9'h000);
		exp_q.push_back({1'b0, par({16'(n), vc, dt})});
		for (int i = 0; i < n; i++)
		begin
			x = 8'h30 + 8'(i);
			exp_q.push_back({1'b0, x});
			for (int b = 0; b < 8; b++)
				c = (c[0] ^ x[b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		exp_q.push_back({1'b0, c[7:0]});
		exp_q.push_back({1'b1, c[15:8]});
		push_short({vc, DT_LE});
	endtask : push_line
	task automatic collect;
		int k;
		k = 0;
		while (sink.got.size() < exp_q.size() && k < 5000)
		begin
			@(posedge clock);
			k++;
		end
		if (k == 5000)
		begin
			err_count++;
			tally_and_finish;
		end
		repeat (40) @(posedge clock);
		check(9'(sink.got.size()), 9'(exp_q.size()));
		for (int i = 0; i < exp_q.size() && i < sink.got.size(); i++)
			check(sink.got[i], exp_q[i]);
		exp_q.delete();
		sink.got.delete();
	endtask : collect
	// ---------------------------------------------------------------
	// clock and sequence
	// ---------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		pin = '0;
		slow = 1'b0;
		inv = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		rd(ADDR_MINSET, RST_MINSET);
		rd(ADDR_RAW10, RST_RAW10);
		rd(ADDR_RAW12, RST_RAW12);
		rd(ADDR_POL, RST_POL);
		rd(8'h20, RST_ZERO);
		for (int r = 0; r < 4; r++)
		begin
			wr(ADDR_RATE, 8'(r));
			#1 check(9'(lane_rate), 9'(r));
			check({1'b0, lane_timing}, {1'b0, AUTO_T[r]});
			check(9'(lane_timing_missing), 9'(r == 3));
		end
		wr(ADDR_TIMING, 8'ha5);
		#1 check({1'b0, lane_timing}, 9'h025);
		check(9'(lane_timing_missing), 9'h000);
		wr(ADDR_RATE, 8'h00);
		#1 check({1'b0, lane_timing}, {1'b0, T16});
		// inverted framing, remapped channel, stalling sink
		wr(ADDR_MINSET, 8'h04);
		wr(ADDR_POL, 8'h11);
		wr(ADDR_REMAP0, 8'he6);
		inv = 1'b1;
		pin[0].frame <= 1'b1;
		pin[0].line <= 1'b1;
		slow = 1'b1;
		push_short({2'h2, DT_FS});
		push_line(2'h2, RST_RAW10[5:0], 5);
		push_short({2'h2, DT_FE});
		frame(6, 5);
		collect;
		// short setup: line dropped, then forwarded
		wr(ADDR_POL, RST_POL);
		inv = 1'b0;
		pin[0].frame <= 1'b0;
		pin[0].line <= 1'b0;
		slow = 1'b0;
		push_short({2'h2, DT_FS});
		push_short({2'h2, DT_FE});
		frame(1, 3);
		collect;
		rd(ADDR_STATUS, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_FWD, 8'h01);
		wr(ADDR_MODE, 8'h10);
		push_short({2'h2, DT_FS});
		push_line(2'h2, RST_RAW12[5:0], 3);
		push_short({2'h2, DT_FE});
		frame(1, 3);
		collect;
		// csi input: type passes through, channel remapped, full depth
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_REMAP0, 8'hec);
		pin[0].vc <= 2'h1;
		pin[0].dt <= 6'h24;
		push_short({2'h3, DT_FS});
		push_line(2'h3, 6'h24, 8);
		push_short({2'h3, DT_FE});
		frame(6, 8);
		collect;
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
